/* File: core/swb_pkg.sv */
package swb_pkg;

    localparam int CLK_HZ = 20_000_000;

    // broadcast rate codes held in the rate-select field
    localparam logic [1:0] RATE_1024K = 2'd0;
    localparam logic [1:0] RATE_512K  = 2'd1;
    localparam logic [1:0] RATE_128K  = 2'd2;
    localparam logic [1:0] RATE_32K   = 2'd3;

    localparam int RATE_KBPS_0 = 1024;
    localparam int RATE_KBPS_1 = 512;
    localparam int RATE_KBPS_2 = 128;
    localparam int RATE_KBPS_3 = 32;

    // clock cycles per Manchester half cell, rounded down so the bit rate is never slower
    localparam int HALF_CYC_0 = CLK_HZ / (2 * RATE_KBPS_0 * 1000);
    localparam int HALF_CYC_1 = CLK_HZ / (2 * RATE_KBPS_1 * 1000);
    localparam int HALF_CYC_2 = CLK_HZ / (2 * RATE_KBPS_2 * 1000);
    localparam int HALF_CYC_3 = CLK_HZ / (2 * RATE_KBPS_3 * 1000);

    localparam logic [9:0] HALF_LIM_0 = 10'(HALF_CYC_0 - 1);
    localparam logic [9:0] HALF_LIM_1 = 10'(HALF_CYC_1 - 1);
    localparam logic [9:0] HALF_LIM_2 = 10'(HALF_CYC_2 - 1);
    localparam logic [9:0] HALF_LIM_3 = 10'(HALF_CYC_3 - 1);

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_STATE_SUMMARY = 6'h00;
    localparam logic [5:0] IDX_CONV_FLAGS    = 6'h01;
    localparam logic [5:0] IDX_GP_INPUTS     = 6'h02;
    localparam logic [5:0] IDX_LIVE_FAULTS   = 6'h03;
    localparam logic [5:0] IDX_LATCHED_FAULT = 6'h04;
    localparam logic [5:0] IDX_ALARM_LOG_LO  = 6'h05;
    localparam logic [5:0] IDX_ALARM_LOG_HI  = 6'h06;
    localparam logic [5:0] IDX_SYSTEM_SETUP  = 6'h0d;

    localparam logic [23:0] SETUP_RESET     = 24'h0cc000;
    localparam logic [7:0]  LATCHED_RESET   = 8'h00;
    localparam logic [39:0] ALARM_RESET     = 40'h0000000000;
    localparam int          RATE_SEL_LSB    = 0;
    localparam int          SAMPLE8_BIT     = 2;

    localparam logic [7:0] PREAMBLE  = 8'h2a;
    localparam logic [7:0] CRC_POLY  = 8'h07;
    localparam logic [7:0] CRC_INIT  = 8'h00;
    localparam logic [7:0] BODY_BITS = 8'd152;
    localparam logic [7:0] PKT_BITS  = 8'd160;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_SEND = 2'b11,
        ST_DONE = 2'b10
    } fsm_type;

    typedef struct packed {
        logic [15:0] sense;
        logic [15:0] rtn;
        logic [15:0] power;
        logic [15:0] aux;
        logic        aux_valid;
        logic [3:0]  aux_tag;
    } entry_type;

    typedef struct packed {
        logic              strap_hi_s1;
        logic              strap_hi_s2;
        logic              strap_lo_s1;
        logic              strap_lo_s2;
        logic              bcast;
        logic              boot_done;
        logic              nvm_rd;
        logic [23:0]       setup;
        logic [7:0]        latched;
        logic [39:0]       alarm;
        logic [15:0]       aux;
        logic [3:0]        aux_tag;
        entry_type [1:0]   buf_mem;
        logic              wr_ptr;
        logic              rd_ptr;
        logic [1:0]        cnt;
        logic              ready;
        fsm_type           state;
        logic [151:0]      shreg;
        logic [7:0]        crc;
        logic [7:0]        bit_cnt;
        logic              half;
        logic [9:0]        half_cnt;
        logic [9:0]        half_lim;
        logic              pin;
        logic              pin_oe_n;
        logic              i2c_en;
        logic              active;
        logic [31:0]       rdata;
        logic              waitreq;
    } state_type;

endpackage : swb_pkg

/* File: core/single_wire_status_broadcast.sv */
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module single_wire_status_broadcast
    import swb_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  avm_address_i,
    input  wire logic        avm_read_i,
    input  wire logic        avm_write_i,
    input  wire logic [31:0] avm_writedata_i,
    output logic      [31:0] avm_readdata_o,
    output logic             avm_waitrequest_o,
    input  wire logic        addr_strap_high_pin_i,
    input  wire logic        addr_strap_low_pin_i,
    output logic             serial_data_out_pin_o,
    output logic             serial_data_out_pin_oe_n_o,
    input  wire logic        i2c_sda_pull_i,
    output logic             i2c_enable_o,
    output logic             broadcast_mode_o,
    output logic             packet_active_o,
    output logic             nvm_rd_o,
    input  wire logic        nvm_ack_i,
    input  wire logic [23:0] nvm_data_i,
    input  wire logic        conv_valid_i,
    output logic             conv_ready_o,
    input  wire logic [15:0] sense_i,
    input  wire logic [15:0] return_node_voltage_i,
    input  wire logic [15:0] power_i,
    input  wire logic [15:0] aux_measurement_i,
    input  wire logic        aux_valid_i,
    input  wire logic [3:0]  aux_channel_tag_i,
    input  wire logic [7:0]  state_summary_i,
    input  wire logic [3:0]  conv_flags_i,
    input  wire logic [7:0]  gp_input_levels_i,
    input  wire logic [7:0]  live_faults_i,
    input  wire logic [7:0]  fault_set_i,
    input  wire logic [39:0] alarm_set_i
);

    localparam state_type ST_RESET = '{
        setup:    SETUP_RESET,
        latched:  LATCHED_RESET,
        alarm:    ALARM_RESET,
        nvm_rd:   1'b1,
        ready:    1'b1,
        state:    ST_IDLE,
        half_lim: HALF_LIM_0,
        pin:      1'b1,
        pin_oe_n: 1'b1,
        i2c_en:   1'b1,
        waitreq:  1'b1,
        default:  '0
    };

    state_type   st_q;
    state_type   st_d;
    entry_type   head;
    entry_type   entry_in;
    logic        push;
    logic        pop;
    logic        wr_go;
    logic        fb;
    logic [7:0]  crc_next;
    logic [5:0]  idx;
    logic        aligned;
    logic [31:0] rd_mux;
    logic [1:0]  rate_code;
    logic [1:0]  eff_rate;
    logic [9:0]  eff_lim;
    logic [15:0] aux_new;
    logic [3:0]  tag_new;

    always_comb
    begin
        st_d      = st_q;
        pop       = 1'b0;
        head      = st_q.buf_mem[st_q.rd_ptr];
        entry_in  = '{sense: sense_i, rtn: return_node_voltage_i, power: power_i,
                      aux: aux_measurement_i, aux_valid: aux_valid_i,
                      aux_tag: aux_channel_tag_i};
        idx       = avm_address_i[7:2];
        aligned   = (avm_address_i[1:0] == 2'b00);
        wr_go     = avm_write_i & ~st_q.waitreq & aligned;
        push      = conv_valid_i & st_q.ready;
        // newest aux result wins, at most one per converter cycle
        aux_new   = head.aux_valid ? head.aux : st_q.aux;
        tag_new   = head.aux_valid ? head.aux_tag : st_q.aux_tag;
        fb        = st_q.crc[7] ^ st_q.shreg[151];
        crc_next  = {st_q.crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);

        rate_code = st_q.setup[RATE_SEL_LSB +: 2];
        eff_rate  = rate_code;
        if (st_q.setup[SAMPLE8_BIT] && (rate_code >= RATE_128K))
        begin
            eff_rate = RATE_512K;
        end
        case (eff_rate)
            RATE_1024K: eff_lim = HALF_LIM_0;
            RATE_512K:  eff_lim = HALF_LIM_1;
            RATE_128K:  eff_lim = HALF_LIM_2;
            default:    eff_lim = HALF_LIM_3;
        endcase

        // strap pins: two flops before use
        st_d.strap_hi_s1 = addr_strap_high_pin_i;
        st_d.strap_hi_s2 = st_q.strap_hi_s1;
        st_d.strap_lo_s1 = addr_strap_low_pin_i;
        st_d.strap_lo_s2 = st_q.strap_lo_s1;
        st_d.bcast       = st_q.strap_hi_s2 & ~st_q.strap_lo_s2;
        st_d.i2c_en      = ~st_d.bcast;

        // stored setup copied in once after reset
        if (!st_q.boot_done && nvm_ack_i)
        begin
            st_d.setup     = nvm_data_i;
            st_d.boot_done = 1'b1;
            st_d.nvm_rd    = 1'b0;
        end

        // register read mux
        rd_mux = 32'h00000000;
        if (!aligned)
        begin
            rd_mux = 32'h00000000;
        end
        else if (idx == IDX_STATE_SUMMARY)
        begin
            rd_mux = {24'h000000, state_summary_i};
        end
        else if (idx == IDX_CONV_FLAGS)
        begin
            rd_mux = {24'h000000, st_q.aux_tag, conv_flags_i};
        end
        else if (idx == IDX_GP_INPUTS)
        begin
            rd_mux = {24'h000000, gp_input_levels_i};
        end
        else if (idx == IDX_LIVE_FAULTS)
        begin
            rd_mux = {24'h000000, live_faults_i};
        end
        else if (idx == IDX_LATCHED_FAULT)
        begin
            rd_mux = {24'h000000, st_q.latched};
        end
        else if (idx == IDX_ALARM_LOG_LO)
        begin
            rd_mux = st_q.alarm[31:0];
        end
        else if (idx == IDX_ALARM_LOG_HI)
        begin
            rd_mux = {24'h000000, st_q.alarm[39:32]};
        end
        else if (idx == IDX_SYSTEM_SETUP)
        begin
            rd_mux = {8'h00, st_q.setup};
        end

        // bus answer one cycle after the request, held off until setup is loaded
        st_d.waitreq = 1'b1;
        if ((avm_read_i || avm_write_i) && st_q.waitreq && st_q.boot_done)
        begin
            st_d.waitreq = 1'b0;
            st_d.rdata   = rd_mux;
        end

        if (wr_go)
        begin
            if (idx == IDX_LATCHED_FAULT)
            begin
                st_d.latched = avm_writedata_i[7:0];
            end
            else if (idx == IDX_ALARM_LOG_LO)
            begin
                st_d.alarm[31:0] = avm_writedata_i;
            end
            else if (idx == IDX_ALARM_LOG_HI)
            begin
                st_d.alarm[39:32] = avm_writedata_i[7:0];
            end
            else if (idx == IDX_SYSTEM_SETUP)
            begin
                st_d.setup = avm_writedata_i[23:0];
            end
        end
        // hardware set beats a software clear in the same cycle
        st_d.latched = st_d.latched | fault_set_i;
        st_d.alarm   = st_d.alarm | alarm_set_i;

        case (st_q.state)
            ST_IDLE:
            begin
                if ((st_q.cnt != 2'd0) && st_q.boot_done)
                begin
                    if (st_q.bcast)
                    begin
                        st_d.state = ST_LOAD;
                    end
                    else
                    begin
                        // not broadcasting: drain updates, keep aux result fresh
                        pop          = 1'b1;
                        st_d.aux     = aux_new;
                        st_d.aux_tag = tag_new;
                    end
                end
            end
            ST_LOAD:
            begin
                pop           = 1'b1;
                st_d.aux      = aux_new;
                st_d.aux_tag  = tag_new;
                // one snapshot of every field at packet start
                st_d.shreg    = {PREAMBLE, head.sense, head.rtn, head.power,
                                 aux_new, state_summary_i, tag_new, conv_flags_i,
                                 gp_input_levels_i, live_faults_i, st_q.latched,
                                 st_q.alarm};
                st_d.crc      = CRC_INIT;
                st_d.bit_cnt  = 8'd0;
                st_d.half     = 1'b0;
                st_d.half_cnt = 10'd0;
                st_d.half_lim = eff_lim;
                st_d.state    = ST_SEND;
            end
            ST_SEND:
            begin
                if (st_q.half_cnt == st_q.half_lim)
                begin
                    st_d.half_cnt = 10'd0;
                    st_d.half     = ~st_q.half;
                    if (st_q.half)
                    begin
                        st_d.bit_cnt = st_q.bit_cnt + 8'd1;
                        st_d.shreg   = {st_q.shreg[150:0], 1'b0};
                        if (st_q.bit_cnt < BODY_BITS)
                        begin
                            st_d.crc = crc_next;
                        end
                        if (st_q.bit_cnt == BODY_BITS - 8'd1)
                        begin
                            st_d.shreg[151:144] = crc_next;
                        end
                        if (st_q.bit_cnt == PKT_BITS - 8'd1)
                        begin
                            st_d.state = ST_DONE;
                        end
                    end
                end
                else
                begin
                    st_d.half_cnt = st_q.half_cnt + 10'd1;
                end
            end
            default:
            begin
                st_d.state = ST_IDLE;
            end
        endcase

        // two-entry buffer; the next update waits here while a packet is sent
        if (push)
        begin
            st_d.buf_mem[st_q.wr_ptr] = entry_in;
            st_d.wr_ptr = ~st_q.wr_ptr;
        end
        if (pop)
        begin
            st_d.rd_ptr = ~st_q.rd_ptr;
        end
        st_d.cnt    = st_q.cnt + {1'b0, push} - {1'b0, pop};
        st_d.ready  = (st_d.cnt != 2'd2);
        st_d.active = (st_d.state != ST_IDLE);

        // first half carries the bit, second its inverse: one falls mid-cell
        if (st_d.bcast)
        begin
            st_d.pin_oe_n = 1'b0;
            if (st_d.state == ST_SEND)
            begin
                st_d.pin = st_d.half ? ~st_d.shreg[151] : st_d.shreg[151];
            end
            else
            begin
                st_d.pin = 1'b1;
            end
        end
        else
        begin
            st_d.pin      = 1'b0;
            st_d.pin_oe_n = ~i2c_sda_pull_i;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_q <= ST_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign avm_readdata_o             = st_q.rdata;
    assign avm_waitrequest_o          = st_q.waitreq;
    assign serial_data_out_pin_o      = st_q.pin;
    assign serial_data_out_pin_oe_n_o = st_q.pin_oe_n;
    assign i2c_enable_o               = st_q.i2c_en;
    assign broadcast_mode_o           = st_q.bcast;
    assign packet_active_o            = st_q.active;
    assign nvm_rd_o                   = st_q.nvm_rd;
    assign conv_ready_o               = st_q.ready;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    boot_load_a: assert property ($rose(st_q.boot_done) |-> st_q.setup == $past(nvm_data_i))
        else $error("setup not loaded from nonvolatile memory");

    mode_select_a: assert property ($past(st_q.strap_hi_s2 && !st_q.strap_lo_s2)
        == st_q.bcast)
        else $error("broadcast mode does not follow straps");

    bus_block_a: assert property (st_q.bcast |-> !i2c_enable_o && !serial_data_out_pin_oe_n_o)
        else $error("two-wire bus active in broadcast mode");

    packet_end_a: assert property ((st_q.state == ST_SEND && st_q.half &&
        st_q.half_cnt == st_q.half_lim && st_q.bit_cnt == 8'd159) |=> st_q.state == ST_DONE ##1
        st_q.state == ST_IDLE)
        else $error("packet not 160 bits");

    preamble_a: assert property (st_q.state == ST_LOAD |=> st_q.shreg[151:144] == 8'h2a)
        else $error("preamble missing");

    aux_field_a: assert property (st_q.state == ST_LOAD |=> st_q.shreg[95:80] == st_q.aux &&
        st_q.shreg[71:68] == st_q.aux_tag)
        else $error("aux field or tag wrong");

    mid_cell_a: assert property ((st_q.state == ST_SEND && !st_q.half &&
        st_q.half_cnt == st_q.half_lim) |=> !st_q.bcast ||
        serial_data_out_pin_o != $past(serial_data_out_pin_o))
        else $error("no mid-cell transition");

    crc_byte_a: assert property ((st_q.state == ST_SEND && st_q.half &&
        st_q.half_cnt == st_q.half_lim && st_q.bit_cnt == 8'd151) |=> st_q.shreg[151:144] == st_q.crc)
        else $error("check byte not loaded");

    crc_init_a: assert property (st_q.state == ST_LOAD |=> st_q.crc == 8'h00)
        else $error("crc not cleared at packet start");

    rate_follow_a: assert property ((st_q.state == ST_LOAD && !st_q.setup[SAMPLE8_BIT] &&
        st_q.setup[1:0] == RATE_32K) |=> st_q.half_lim == HALF_LIM_3)
        else $error("rate select not followed");

    rate_floor_a: assert property ((st_q.state == ST_LOAD && st_q.setup[SAMPLE8_BIT] &&
        st_q.setup[1:0] >= RATE_128K) |=> st_q.half_lim == HALF_LIM_1)
        else $error("512k floor not applied");

    buffer_full_a: assert property (st_q.cnt == 2'd2 |-> !conv_ready_o)
        else $error("buffer accepts while full");

    idle_level_a: assert property ((st_q.bcast && st_q.state == ST_IDLE) |->
        serial_data_out_pin_o)
        else $error("idle level not high");

endmodule : single_wire_status_broadcast

`default_nettype wire

/* File: tb/host_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_rx_model
(
    input  wire logic         clk_i,
    input  wire logic         line_i,
    input  wire logic         mode_i,
    input  wire logic [9:0]   half_i,
    output var  logic [159:0] pkt_o = '0,
    output var  logic [7:0]   cnt_o = '0,
    output var  logic [7:0]   bad_o = '0
);
    logic [159:0] sh_q   = '0;
    logic [9:0]   pos_q  = '0;
    logic [7:0]   nb_q   = '0;
    logic         busy_q = 1'b0;
    logic         arm_q  = 1'b0;
    logic         bit_q  = 1'b0;
    always_ff @(posedge clk_i)
    begin
        if (!mode_i)
        begin
            busy_q <= 1'b0; // line not broadcasting: drop any partial frame
            arm_q  <= 1'b0;
        end
        else if (!busy_q)
        begin
            arm_q  <= line_i;
            busy_q <= arm_q && !line_i; // a frame opens with a low half cell after idle high
            pos_q  <= 10'd1;
            nb_q   <= 8'd0;
        end
        else
        begin
            pos_q <= pos_q + 10'd1;
            if (pos_q == (half_i >> 1))
                bit_q <= line_i;
            if (pos_q == half_i + (half_i >> 1) && line_i == bit_q)
                bad_o <= bad_o + 8'd1;
            if (pos_q == (half_i << 1) - 10'd1)
            begin
                pos_q <= 10'd0;
                nb_q  <= nb_q + 8'd1;
                sh_q  <= {sh_q[158:0], bit_q};
                if (nb_q == 8'd159)
                begin
                    busy_q <= 1'b0;
                    arm_q  <= 1'b0;
                    pkt_o  <= {sh_q[158:0], bit_q};
                    cnt_o  <= cnt_o + 8'd1;
                end
            end
        end
    end
endmodule : host_rx_model
`default_nettype wire

/* File: tb/single_wire_status_broadcast_test.sv */
`timescale 1ns/1ps
`default_nettype none
module single_wire_status_broadcast_test;
    logic         clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, s_hi = 1'b1, s_lo = 1'b0;
    logic         pull = 1'b0, ack = 1'b0, cv = 1'b0, av = 1'b0;
    logic [7:0]   adr = 8'h00, ss = 8'h3c, gp = 8'h81, live = 8'h42, fset = 8'h00;
    logic [7:0]   lf = 8'h00, pcnt, bad;
    logic [31:0]  wd = 32'h0, rdat, got;
    logic [23:0]  nvd = 24'h0cc001;
    logic [63:0]  upd = 64'h0;
    logic [3:0]   tag = 4'h0, flg = 4'h6, tag_e = 4'h0;
    logic [39:0]  aset = 40'h0, al = 40'h0;
    logic [15:0]  aux_e = 16'h0;
    logic [9:0]   half = 10'd20;
    logic [159:0] pkt;
    logic         wreq, pin, oe_n, i2c_en, bmode, act, nvm_rd, crdy;
    int           n_fail = 0, total_checks = 0, stall = 0;
    always #25 clk = ~clk;
    single_wire_status_broadcast dut (
        .ref_clk_i(clk), .rst_i(rst), .avm_address_i(adr), .avm_read_i(rd),
        .avm_write_i(wr), .avm_writedata_i(wd), .avm_readdata_o(rdat),
        .avm_waitrequest_o(wreq), .addr_strap_high_pin_i(s_hi), .addr_strap_low_pin_i(s_lo),
        .serial_data_out_pin_o(pin), .serial_data_out_pin_oe_n_o(oe_n), .i2c_sda_pull_i(pull),
        .i2c_enable_o(i2c_en), .broadcast_mode_o(bmode), .packet_active_o(act),
        .nvm_rd_o(nvm_rd), .nvm_ack_i(ack), .nvm_data_i(nvd), .conv_valid_i(cv),
        .conv_ready_o(crdy), .sense_i(upd[63:48]), .return_node_voltage_i(upd[47:32]),
        .power_i(upd[31:16]), .aux_measurement_i(upd[15:0]), .aux_valid_i(av),
        .aux_channel_tag_i(tag), .state_summary_i(ss), .conv_flags_i(flg),
        .gp_input_levels_i(gp), .live_faults_i(live), .fault_set_i(fset), .alarm_set_i(aset));
    host_rx_model rx (.clk_i(clk), .line_i(pin), .mode_i(bmode), .half_i(half), .pkt_o(pkt),
        .cnt_o(pcnt), .bad_o(bad));
    task automatic chk(input string w, input logic [159:0] s, input logic [159:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", w, e, s);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic step(inout int n, input int lim);
        @(posedge clk);
        n++;
        if (n > lim)
        begin
            chk("wait bound", 160'd1, 160'd0);
            close_out();
        end
    endtask : step
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        step(n, 100);
        while (wreq !== 1'b0)
            step(n, 100);
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(w, {128'h0, got}, {128'h0, e});
    endtask : rchk
    task automatic boot;
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        chk("reset outputs", {152'h0, wreq, pin, oe_n, i2c_en, bmode, act, nvm_rd, crdy},
            160'hf3);
        rst <= 1'b0;
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (3) @(posedge clk);
        chk("boot read", {159'h0, nvm_rd}, 160'h0);
    endtask : boot
    task automatic expect_pkt(input logic [63:0] v, input logic va, input logic [3:0] t,
                              output logic [159:0] e);
        logic [151:0] b;
        logic [7:0]   c;
        if (va)
        begin
            aux_e = v[15:0];
            tag_e = t;
        end
        b = {8'h2a, v[63:16], aux_e, ss, tag_e, flg, gp, live, lf, al};
        c = 8'h00;
        for (int i = 151; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
        e = {b, c};
    endtask : expect_pkt
    task automatic push(input logic [63:0] v, input logic va, input logic [3:0] t);
        int n;
        n = 0;
        upd <= v;
        av <= va;
        tag <= t;
        cv <= 1'b1;
        step(n, 40000);
        while (crdy !== 1'b1)
            step(n, 40000);
        stall += n - 1;
    endtask : push
    task automatic wait_pkt;
        int         n;
        logic [7:0] c;
        n = 0;
        c = pcnt;
        while (pcnt === c)
            step(n, 60000);
    endtask : wait_pkt
    task automatic t_mode;
        for (int k = 0; k < 3; k++)
        begin
            s_hi <= k != 0;
            s_lo <= k == 1;
            pull <= 1'b1;
            repeat (5) @(posedge clk);
            chk("strap mode", {157'h0, bmode, i2c_en, oe_n}, (k == 2) ? 160'h4 : 160'h2);
        end
        chk("idle line", {159'h0, pin}, 160'h1);
        pull <= 1'b0;
        $display("mode test done");
    endtask : t_mode
    task automatic t_regs;
        rchk("setup after boot", 8'h34, 32'h000cc001);
        rchk("latched reset", 8'h10, 32'h0);
        rchk("alarm lo reset", 8'h14, 32'h0);
        rchk("alarm hi reset", 8'h18, 32'h0);
        bus(1'b1, 8'h00, 32'hff);
        rchk("summary read only", 8'h00, {24'h0, ss});
        rchk("unmapped", 8'h3c, 32'h0);
        rchk("unaligned", 8'h35, 32'h0);
        rchk("gp inputs", 8'h08, {24'h0, gp});
        bus(1'b1, 8'h10, 32'h5a);
        fset <= 8'h81;
        @(posedge clk);
        fset <= 8'h00;
        lf = 8'hdb;
        rchk("latched set", 8'h10, {24'h0, lf});
        bus(1'b1, 8'h14, 32'h12345678);
        bus(1'b1, 8'h18, 32'h9a);
        al = 40'h9a12345678;
        rchk("alarm hi", 8'h18, {24'h0, al[39:32]});
        $display("register test done");
    endtask : t_regs
    task automatic t_pkt(input logic [23:0] su, input logic [9:0] h, input logic [63:0] v,
                         input logic va, input logic [3:0] t);
        logic [159:0] e;
        int           n;
        n = 0;
        if (su !== 24'h0)
            bus(1'b1, 8'h34, {8'h00, su});
        half <= h;
        expect_pkt(v, va, t, e);
        push(v, va, t);
        cv <= 1'b0;
        while (act !== 1'b1)
            step(n, 20);
        ss <= ~ss; // a change after load must not reach this packet
        wait_pkt();
        chk("packet", pkt, e);
        rchk("flags reg", 8'h04, {24'h0, tag_e, flg});
        $display("packet test done, half cell %0d", h);
    endtask : t_pkt
    task automatic t_burst;
        logic [159:0] e [4];
        half <= 10'd9;
        bus(1'b1, 8'h34, 32'h000cc000);
        for (int k = 0; k < 4; k++)
            expect_pkt({4{12'h0a0, k[3:0]}}, k != 1, k[3:0] + 4'h2, e[k]);
        fork
            begin
                for (int k = 0; k < 4; k++)
                    push({4{12'h0a0, k[3:0]}}, k != 1, k[3:0] + 4'h2);
                cv <= 1'b0;
            end
            for (int j = 0; j < 4; j++)
            begin
                wait_pkt();
                chk("burst packet", pkt, e[j]);
            end
        join
        chk("burst stalled", 160'(stall > 0), 160'd1);
        chk("line coding", {152'h0, bad}, 160'h0);
        $display("burst test done");
    endtask : t_burst
    task automatic t_reset;
        int n;
        n = 0;
        bus(1'b1, 8'h34, 32'h000cc003);
        half <= 10'd312;
        push(64'h0, 1'b0, 4'h0);
        cv <= 1'b0;
        while (act !== 1'b1)
            step(n, 20);
        n = 0;
        step(n, 400);
        while (pin === 1'b0)
            step(n, 400);
        chk("32k half cell", 160'(n - 1), 160'd312);
        boot();
        rchk("setup after reboot", 8'h34, 32'h000cc001);
        rchk("latched after reboot", 8'h10, 32'h0);
        $display("reset test done");
    endtask : t_reset
    initial
    begin
        boot();
        t_mode();
        t_regs();
        t_pkt(24'h0, 10'd19, 64'h8001_7ffe_0102_a5c3, 1'b1, 4'h5);
        t_pkt(24'h0cc000, 10'd9, 64'hffff_0000_1234_5678, 1'b0, 4'h3);
        t_pkt(24'h0cc002, 10'd78, 64'h0f0f_f0f0_00ff_ff00, 1'b1, 4'hf);
        t_pkt(24'h0cc007, 10'd19, 64'h1357_9bdf_2468_ace0, 1'b1, 4'h1);
        t_pkt(24'h0cc006, 10'd19, 64'h0001_8000_7fff_fffe, 1'b1, 4'h8);
        t_burst();
        t_reset();
        close_out();
    end
endmodule : single_wire_status_broadcast_test
`default_nettype wire
